// ==== inc/hpp_pkg.sv ====
// Package: register map, field positions and reset values of the host parallel port
package hpp_pkg;
    // Register indices (printed offsets are not all multiples of four: byte address is index * 4)
    localparam logic [7:0] IDX_HOST_DATA_LATCH      = 8'h08;
    localparam logic [7:0] IDX_CONTROL_PIN_LEVELS   = 8'h09;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_CONTROL_DIRECTION    = 8'h89;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENA   = 8'h8c;
    localparam logic [7:0] IDX_ANALOG_PIN_CONFIG    = 8'h9f;
    localparam int         ADDR_W                   = 10;
    // Control/direction register fields
    localparam int         BIT_INPUT_FULL           = 7;
    localparam int         BIT_OUTPUT_FULL          = 6;
    localparam int         BIT_OVERFLOW             = 5;
    localparam int         BIT_PORT_SELECT          = 4;
    localparam int         BIT_UNUSED               = 3;
    localparam logic [2:0] DIR_RESET                = 3'h7;
    // Interrupt flag and enable position
    localparam int         BIT_PORT_IRQ             = 7;
    localparam logic [7:0] IRQ_RESET                = 8'h00;
    localparam logic [7:0] ANALOG_CFG_RESET         = 8'h00;
    // Analog config values below this one leave all three control pins analog
    localparam logic [3:0] PCFG_DIGITAL_MIN         = 4'h6;
    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ            = 2'h2;
endpackage : hpp_pkg

// ==== hw/hpp_sync.sv ====
// Two-flop synchroniser for the host control strobes
`timescale 1ns/100ps
module hpp_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_reg <= INIT;
            q        <= INIT;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : hpp_sync

// ==== hw/hpp_top.sv ====
// Host parallel slave port with AHB-Lite register access
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module hpp_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  host_data_in,
    output logic      [7:0]  host_data_out,
    output logic             host_data_oe,
    input  wire logic        read_strobe_pin_b,
    input  wire logic        write_strobe_pin_b,
    input  wire logic        chip_select_pin_b,
    output logic      [2:0]  control_pin_out,
    output logic      [2:0]  control_pin_oe,
    output logic             irq
);
    logic [7:0] host_data_latch_reg;
    logic [7:0] input_data_reg;
    logic [2:0] pin_out_reg;
    logic [2:0] dir_reg;
    logic       input_full_flag;
    logic       output_full_flag;
    logic       input_overflow_flag;
    logic       slave_port_select;
    logic [7:0] irq_flags_reg;
    logic [7:0] irq_enables_reg;
    logic [7:0] analog_cfg_reg;
    logic [2:0] pins_sync;
    logic [7:0] data_sync;
    logic       rd_act_reg;
    logic       wr_act_reg;
    logic       dp_wr_reg;
    logic       dp_rd_reg;
    logic [7:0] dp_idx_reg;
    logic       host_rd_sel;
    logic       host_wr_sel;
    logic       host_rd_end;
    logic       host_wr_end;
    logic       cpu_wr;
    logic [7:0] wbyte;
    logic [7:0] rd_value;
    logic [2:0] pin_view;
    logic       analog_all;

    // Index width: the highest index fits in eight bits
    localparam int ADDR_W_L = 8;

    // Register index decode: byte address is four times the printed offset
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        reg_index = a[ADDR_W_L+1:2];
    endfunction : reg_index

    // Register accesses complete with no wait state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            dp_wr_reg  <= 1'b0;
            dp_rd_reg  <= 1'b0;
            dp_idx_reg <= 8'h00;
        end
        else if (hready)
        begin
            dp_wr_reg  <= hsel && htrans == hpp_pkg::HTRANS_NONSEQ && hwrite;
            dp_rd_reg  <= hsel && htrans == hpp_pkg::HTRANS_NONSEQ && !hwrite;
            dp_idx_reg <= (haddr[31:ADDR_W_L+2] == '0 && haddr[1:0] == 2'h0)
                          ? reg_index(haddr) : 8'hff;
        end
    end

    assign cpu_wr = dp_wr_reg;
    assign wbyte  = hwdata[7:0];

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Host strobes pass the synchroniser first; reset value is idle-high.
    // Data rides the same two stages, so it stays aligned with the delayed
    // strobes and a host that drops the bus with the strobe is still caught
    hpp_sync #(
        .W    (11),
        .INIT (11'h007)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({host_data_in, chip_select_pin_b, write_strobe_pin_b, read_strobe_pin_b}),
        .q     ({data_sync, pins_sync})
    );

    // Pins all analog below the digital threshold; they then read zero and
    // cannot act as strobes, which also guards a misconfigured slave port
    assign analog_all = analog_cfg_reg[3:0] < hpp_pkg::PCFG_DIGITAL_MIN;

    assign host_rd_sel = slave_port_select && !analog_all
                         && !pins_sync[2] && !pins_sync[0];
    assign host_wr_sel = slave_port_select && !analog_all
                         && !pins_sync[2] && !pins_sync[1];

    // Activity trackers: access registered on first detection, ended on release
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rd_act_reg <= 1'b0;
            wr_act_reg <= 1'b0;
        end
        else
        begin
            rd_act_reg <= host_rd_sel;
            wr_act_reg <= host_wr_sel;
        end
    end

    assign host_rd_end = rd_act_reg && !host_rd_sel;
    assign host_wr_end = wr_act_reg && !host_wr_sel;

    // Data captured on every cycle of a write so the final bus value is kept
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            input_data_reg <= 8'h00;
        else if (host_wr_sel)
            input_data_reg <= data_sync;
    end

    // CPU side of the port latch
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            host_data_latch_reg <= 8'h00;
        else if (cpu_wr && dp_idx_reg == hpp_pkg::IDX_HOST_DATA_LATCH)
            host_data_latch_reg <= wbyte;
    end

    // Status flags; hardware set wins over software clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            input_full_flag     <= 1'b0;
            output_full_flag    <= 1'b0;
            input_overflow_flag <= 1'b0;
        end
        else
        begin
            if (host_wr_end)
                input_full_flag <= 1'b1;
            else if (dp_rd_reg && dp_idx_reg == hpp_pkg::IDX_HOST_DATA_LATCH)
                input_full_flag <= 1'b0;
            if (cpu_wr && dp_idx_reg == hpp_pkg::IDX_HOST_DATA_LATCH)
                output_full_flag <= 1'b1;
            else if (host_rd_end)
                output_full_flag <= 1'b0;
            if (host_wr_end && input_full_flag)
                input_overflow_flag <= 1'b1;
            else if (cpu_wr && dp_idx_reg == hpp_pkg::IDX_CONTROL_DIRECTION
                     && !wbyte[hpp_pkg::BIT_OVERFLOW])
                input_overflow_flag <= 1'b0;
        end
    end

    // Mode and direction bits; bit 3 has no storage
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            slave_port_select <= 1'b0;
            dir_reg           <= hpp_pkg::DIR_RESET;
        end
        else if (cpu_wr && dp_idx_reg == hpp_pkg::IDX_CONTROL_DIRECTION)
        begin
            slave_port_select <= wbyte[hpp_pkg::BIT_PORT_SELECT];
            dir_reg           <= wbyte[2:0];
        end
    end

    // Pin levels, analog config and interrupt enable registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pin_out_reg     <= 3'h0;
            analog_cfg_reg  <= hpp_pkg::ANALOG_CFG_RESET;
            irq_enables_reg <= hpp_pkg::IRQ_RESET;
        end
        else if (cpu_wr)
        begin
            if (dp_idx_reg == hpp_pkg::IDX_CONTROL_PIN_LEVELS)
                pin_out_reg <= wbyte[2:0];
            if (dp_idx_reg == hpp_pkg::IDX_ANALOG_PIN_CONFIG)
                analog_cfg_reg <= wbyte;
            if (dp_idx_reg == hpp_pkg::IDX_PERIPHERAL_IRQ_ENA)
                irq_enables_reg <= wbyte;
        end
    end

    // Sticky flags: write one clears, a new event in the same cycle wins
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq_flags_reg <= hpp_pkg::IRQ_RESET;
        else
        begin
            if (cpu_wr && dp_idx_reg == hpp_pkg::IDX_PERIPHERAL_IRQ_FLAGS)
                irq_flags_reg <= irq_flags_reg & ~wbyte;
            if (host_rd_end || host_wr_end)
                irq_flags_reg[hpp_pkg::BIT_PORT_IRQ] <= 1'b1;
        end
    end

    // Level interrupt from a registered mask of the flags
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(irq_flags_reg & irq_enables_reg);
    end

    // Pin view: analog pins read zero, slave port mode reads the strobes
    assign pin_view = analog_all ? 3'h0 : pins_sync;

    always_comb
    begin
        case (dp_idx_reg)
            hpp_pkg::IDX_HOST_DATA_LATCH:
                rd_value = slave_port_select ? input_data_reg : host_data_in;
            hpp_pkg::IDX_CONTROL_PIN_LEVELS:
                rd_value = {5'h00, pin_view};
            hpp_pkg::IDX_PERIPHERAL_IRQ_FLAGS:
                rd_value = irq_flags_reg;
            hpp_pkg::IDX_CONTROL_DIRECTION:
                rd_value = {input_full_flag, output_full_flag, input_overflow_flag,
                            slave_port_select, 1'b0, dir_reg};
            hpp_pkg::IDX_PERIPHERAL_IRQ_ENA:
                rd_value = irq_enables_reg;
            hpp_pkg::IDX_ANALOG_PIN_CONFIG:
                rd_value = analog_cfg_reg;
            default:
                rd_value = 8'h00;
        endcase
    end

    // Read data is presented combinationally in the data phase
    assign hrdata = {24'h000000, rd_value};

    // Data bus drive: output latch is driven only during a host read in slave mode
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            host_data_out <= 8'h00;
            host_data_oe  <= 1'b0;
        end
        else
        begin
            host_data_out <= host_data_latch_reg;
            host_data_oe  <= slave_port_select && host_rd_sel;
        end
    end

    // Control pins are inputs in slave mode; direction bit one means input
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            control_pin_out <= 3'h0;
            control_pin_oe  <= 3'h0;
        end
        else
        begin
            control_pin_out <= pin_out_reg;
            control_pin_oe  <= slave_port_select ? 3'h0 : ~dir_reg;
        end
    end
endmodule : hpp_top

// ==== testbench/hpp_checker.sv ====
// Checker: bus answers and host strobe timing of the parallel port
`timescale 1ns/100ps
module hpp_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        host_data_oe,
    input wire logic        read_strobe_pin_b,
    input wire logic        chip_select_pin_b,
    input wire logic [2:0]  control_pin_oe,
    input wire logic        irq
);
    logic        rd_d;
    logic        wr_d;
    logic [31:0] a_d;
    logic        take;

    assign take = hsel && hready && htrans == hpp_pkg::HTRANS_NONSEQ;

    // Data phase tracking, so checks see the answer of the taken request
    always_ff @(posedge clk)
    begin
        rd_d <= rst_b && take && !hwrite;
        wr_d <= rst_b && take && hwrite;
        a_d  <= haddr;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    a_bit3_zero: assert property (rd_d && a_d == 32'h224 |-> hrdata[3] == 1'b0)
        else $error("control bit 3 read as one");
    a_unmapped_zero: assert property (rd_d && a_d >= 32'h400 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_oe_cause: assert property ($rose(host_data_oe) |->
        !$past(read_strobe_pin_b, 2) && !$past(chip_select_pin_b, 2))
        else $error("data driven without selected read");
    a_oe_release: assert property ($rose(read_strobe_pin_b) |-> ##[1:4] !host_data_oe)
        else $error("data still driven after read");
    a_pins_input: assert property ($rose(rst_b) |-> control_pin_oe == 3'h0 [*3])
        else $error("control pins driven after reset");
    a_irq_mask: assert property (wr_d && a_d == 32'h230 && hwdata[7:0] == 8'h00
        |=> ##1 !irq)
        else $error("masked interrupt still raised");
endmodule : hpp_checker

// ==== testbench/hpp_host_model.sv ====
// Host model: external processor driving the strobes and data bus
`timescale 1ns/100ps
module hpp_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_oe,
    output logic      [7:0] bus_data,
    output logic            cs_b,
    output logic            rd_b,
    output logic            wr_b
);
    logic [7:0] drv;
    logic       drv_en;

    // Released bus shows the inverse of the last byte, never a stale match
    assign bus_data = dev_oe ? dev_data : (drv_en ? drv : ~drv);

    initial
    begin
        drv = 8'h00;
        drv_en = 1'b0;
        cs_b = 1'b1;
        rd_b = 1'b1;
        wr_b = 1'b1;
    end

    // One strobe of five cycles, then a gap of five
    task automatic access(input logic w, input logic sel, input logic [7:0] val,
                          output logic [7:0] got);
        @(posedge clk);
        drv <= val;
        drv_en <= w;
        cs_b <= !sel;
        wr_b <= !w;
        rd_b <= w;
        repeat (4) @(posedge clk);
        #1 got = bus_data;
        @(posedge clk);
        cs_b <= 1'b1;
        wr_b <= 1'b1;
        rd_b <= 1'b1;
        drv_en <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : access
endmodule : hpp_host_model

// ==== testbench/tb.sv ====
// Testbench: register and host scenarios of the parallel port
`timescale 1ns/100ps
module tb;
    localparam logic [31:0] LAT = 32'h20;
    localparam logic [31:0] FLG = 32'h30;
    localparam logic [31:0] CTL = 32'h224;
    localparam logic [31:0] ENA = 32'h230;
    localparam logic [31:0] ANA = 32'h27c;
    logic        clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  hbus;
    logic [7:0]  dout;
    logic        doe;
    logic        rd_b;
    logic        wr_b;
    logic        cs_b;
    logic        irq;
    logic [2:0]  cpo;
    logic [2:0]  cpoe;
    logic [31:0] v;
    logic [7:0]  hv;
    int          failures;
    int          checked;

    hpp_top i_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .host_data_in(hbus),
        .host_data_out(dout), .host_data_oe(doe), .read_strobe_pin_b(rd_b),
        .write_strobe_pin_b(wr_b), .chip_select_pin_b(cs_b), .control_pin_out(cpo),
        .control_pin_oe(cpoe), .irq);
    hpp_host_model i_host (.clk, .dev_data(dout), .dev_oe(doe), .bus_data(hbus),
        .cs_b, .rd_b, .wr_b);

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // Single AHB transfer; read data lands in v
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= hpp_pkg::HTRANS_NONSEQ;
        @(posedge clk);
        while (!hreadyout)
            @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hreadyout)
            @(posedge clk);
        v = hrdata;
    endtask : bus

    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(n, e, v);
    endtask : rchk

    task automatic end_of_test;
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, far beyond the roughly 130 cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test;
    end

    initial
    begin
        failures = 0;
        checked = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk("control", CTL, 32'h07);
        rchk("flags", FLG, 32'h0);
        rchk("analog", ANA, 32'h0);
        check("pin out", 32'h0, {29'h0, cpo});
        bus(1'b1, CTL, 32'h06);
        repeat (2) @(posedge clk);
        check("pin oe", 32'h1, {29'h0, cpoe});
        bus(1'b1, CTL, 32'hff);
        rchk("control wr", CTL, 32'h17);
        check("pin oe slave", 32'h0, {29'h0, cpoe});
        i_host.access(1'b1, 1'b1, 8'h5a, hv);
        rchk("analog pins", CTL, 32'h17);
        bus(1'b1, ANA, 32'h06);
        bus(1'b1, ENA, 32'h80);
        i_host.access(1'b1, 1'b0, 8'h77, hv);
        rchk("deselected", CTL, 32'h17);
        i_host.access(1'b1, 1'b1, 8'ha5, hv);
        rchk("input full", CTL, 32'h97);
        check("irq", 32'h1, {31'h0, irq});
        rchk("port flag", FLG, 32'h80);
        rchk("latch", LAT, 32'ha5);
        i_host.access(1'b1, 1'b1, 8'h11, hv);
        i_host.access(1'b1, 1'b1, 8'h22, hv);
        rchk("overflow", CTL, 32'hb7);
        bus(1'b1, CTL, 32'h17);
        rchk("overflow clr", CTL, 32'h97);
        rchk("latch last", LAT, 32'h22);
        bus(1'b1, LAT, 32'h3c);
        rchk("output full", CTL, 32'h57);
        i_host.access(1'b0, 1'b1, 8'h00, hv);
        check("host read", 32'h3c, {24'h0, hv});
        rchk("output drained", CTL, 32'h17);
        rchk("unmapped", 32'h400, 32'h0);
        bus(1'b1, ENA, 32'h0);
        repeat (3) @(posedge clk);
        check("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, FLG, 32'h80);
        rchk("flag clr", FLG, 32'h0);
        end_of_test;
    end
endmodule : tb

bind hpp_top hpp_checker i_chk (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .host_data_oe, .read_strobe_pin_b,
    .chip_select_pin_b, .control_pin_oe, .irq);
